// File: design/tepc_pkg.sv
// Package: register map, field positions and types of the timer/event counter
package tepc_pkg;
   localparam logic [1:0] ADDR_COUNT_LO = 2'h0;
   localparam logic [1:0] ADDR_COUNT_HI = 2'h1;
   localparam logic [1:0] ADDR_CONTROL  = 2'h2;
   localparam logic [1:0] ADDR_IRQ_CTRL = 2'h3;
   // Control register fields
   localparam int CTRL_MODE_HI_BIT = 7;
   localparam int CTRL_MODE_LO_BIT = 6;
   localparam int CTRL_RUN_BIT     = 4;
   localparam int CTRL_EDGE_BIT    = 3;
   // Interrupt control register fields
   localparam int IRQ_GLOBAL_BIT = 0;
   localparam int IRQ_ENABLE_BIT = 2;
   localparam int IRQ_FLAG_BIT   = 5;
   // Reset values
   localparam logic [7:0]  CTRL_RESET  = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_FULL  = 16'hffff;
   localparam logic [3:0]  CTRL_FIELDS_RESET = 4'h0;
   localparam logic [2:0]  IRQ_RESET         = 3'h0;
   localparam logic [7:0]  BYTE_RESET        = 8'h00;
   // Internal clock is the system clock divided by four
   localparam int          PRESCALE     = 4;
   localparam logic [1:0]  PRESCALE_TOP = 2'(PRESCALE - 1);
   typedef enum logic [1:0] {
      MODE_OFF   = 2'h0,
      MODE_EVENT = 2'h1,
      MODE_TIMER = 2'h2,
      MODE_PULSE = 2'h3
   } tepc_mode_type;
   typedef struct packed {
      logic mode_sel_hi;
      logic mode_sel_lo;
      logic count_run;
      logic edge_polarity;
   } tepc_ctrl_type;
   typedef struct packed {
      logic global_irq_enable;
      logic overflow_irq_enable;
      logic overflow_flag;
   } tepc_irq_type;
endpackage : tepc_pkg

// File: design/tepc_timer.sv
// Timer/event counter with timer, event-count and pulse-width modes
// Notes on behaviour
// R1 - Mode bits hi=0 lo=1 count pin transitions while count_run is high
// R2 - Event mode: rising edge counts when edge_polarity low, falling when high
// R3 - Passing full count reloads preload value and counting continues, in timer, event and pulse-width modes
// R4 - Event counting continues while the processor is powered down
// R5 - Both mode bits high: pulse-width mode, internal clock gated by pin level
// R6 - Polarity low: count after falling edge, stop and clear count_run on high
// R7 - Polarity high: count after rising edge, stop and clear count_run on low
// R8 - After auto clear, ignore pin and hold count until software sets count_run
// R9 - Timer and event modes never clear count_run in hardware
// R10 - Overflow sets the request flag; interrupt only when its enable is set
// R11 - Clearing the interrupt enable hides the interrupt, counter keeps running
// R12 - Pin level is sampled on the internal timer clock tick
// R13 - Counter clock inhibited during counter read or preload write
// R14 - Internal-clock overflow never wakes the processor from power-down
// R15 - count_run is bit 4 of control register: set starts, clear stops
// R16 - Software sets port direction bit 2 so the input pin is an input
// R17 - Software sets count_run only after mode bits are configured
// R18 - Software loads a start value before enabling the timer
// R19 - Mode bits hi=1 lo=0: timer mode on system clock divided by four
// R20 - Preload write loads counter if stopped, else waits for next overflow
// R21 - Low byte write buffered until high write; high read latches low byte
// R22 - Overflow occurs on passing full count of all ones
// R23 - Both mode bits zero: counter holds and no overflow occurs
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tepc_timer (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [1:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   input  wire logic       timer_input_pin,
   input  wire logic       power_down,
   output logic            irq,
   output logic            wake_req
);
   tepc_pkg::tepc_ctrl_type ctrl;
   tepc_pkg::tepc_ctrl_type next_ctrl;
   tepc_pkg::tepc_irq_type  irqc;
   tepc_pkg::tepc_irq_type  next_irqc;
   tepc_pkg::tepc_mode_type mode;

   typedef enum logic {PW_WAIT, PW_MEAS} tepc_pw_type;
   tepc_pw_type pw_state;
   tepc_pw_type next_pw_state;

   logic [15:0] count;
   logic [15:0] next_count;
   logic [15:0] preload;
   logic [15:0] next_preload;
   logic [7:0]  lo_buf;
   logic [7:0]  next_lo_buf;
   logic [7:0]  rd_lo;
   logic [7:0]  next_rd_lo;
   logic [7:0]  next_rdata;
   logic        next_irq;
   logic        next_wake_req;
   logic [1:0]  presc;
   logic [1:0]  next_presc;
   logic        sync1;
   logic        sync2;
   logic        sync3;
   logic        pin_lvl;
   logic        next_pin_lvl;
   logic        pin_prev;
   logic        tick_lvl;
   logic        next_tick_lvl;
   logic        tick;
   logic        inhibit;
   logic        step;
   logic        ovf;
   logic        act_lvl;
   logic        ev_edge;
   logic        pw_stop;

   function automatic logic is_addr(input logic [1:0] a, input logic [1:0] ref_a);
      return a == ref_a;
   endfunction : is_addr

   assign mode    = tepc_pkg::tepc_mode_type'({ctrl.mode_sel_hi, ctrl.mode_sel_lo});
   assign tick    = (presc == tepc_pkg::PRESCALE_TOP); // [R19]
   assign act_lvl = ctrl.edge_polarity;

   // Pin synchroniser, level accepted once stages two and three agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
      end else begin
         sync1 <= timer_input_pin;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   always_comb begin
      next_pin_lvl  = (sync2 == sync3) ? sync3 : pin_lvl;
      next_tick_lvl = tick ? pin_lvl : tick_lvl; // [R12]
      next_presc    = presc + 2'h1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_lvl  <= 1'b0;
         pin_prev <= 1'b0;
         tick_lvl <= 1'b0;
         presc    <= 2'h0;
      end else begin
         pin_lvl  <= next_pin_lvl;
         pin_prev <= pin_lvl;
         tick_lvl <= next_tick_lvl;
         presc    <= next_presc;
      end
   end

   // Edge into the counted level: rising for polarity low, falling for high
   assign ev_edge = (pin_prev != pin_lvl) && (pin_lvl == !ctrl.edge_polarity); // [R2]
   // Pulse-width active level equals the polarity bit, idle is its inverse
   assign pw_stop = (pw_state == PW_MEAS) && tick && (pin_lvl != act_lvl); // [R6] [R7]

   assign inhibit = (rd || wr) && (is_addr(addr, tepc_pkg::ADDR_COUNT_LO) ||
                                   is_addr(addr, tepc_pkg::ADDR_COUNT_HI)); // [R13]

   // Counting source per mode
   always_comb begin
      step = 1'b0;
      case (mode)
         tepc_pkg::MODE_TIMER: step = ctrl.count_run && tick && !power_down; // [R19]
         tepc_pkg::MODE_EVENT: step = ctrl.count_run && ev_edge; // [R1] [R4]
         tepc_pkg::MODE_PULSE: step = ctrl.count_run && (pw_state == PW_MEAS) && tick &&
                                      (pin_lvl == act_lvl); // [R5] [R8]
         tepc_pkg::MODE_OFF:   step = 1'b0; // [R23]
         default:              step = 1'b0;
      endcase
      step = step && !inhibit; // [R13]
   end

   assign ovf = step && (count == tepc_pkg::COUNT_FULL); // [R22]

   // Pulse-width measurement sequencing
   always_comb begin
      next_pw_state = pw_state;
      case (pw_state)
         PW_WAIT: begin
            if (mode == tepc_pkg::MODE_PULSE && ctrl.count_run && tick &&
                tick_lvl == !act_lvl && pin_lvl == act_lvl) begin
               next_pw_state = PW_MEAS; // [R6] [R7]
            end
         end
         PW_MEAS: begin
            if (mode != tepc_pkg::MODE_PULSE || !ctrl.count_run || pw_stop) begin
               next_pw_state = PW_WAIT;
            end
         end
         default: next_pw_state = PW_WAIT;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pw_state <= PW_WAIT;
      end else begin
         pw_state <= next_pw_state;
      end
   end

   // Registers, counter and read path
   always_comb begin
      next_ctrl     = ctrl;
      next_irqc     = irqc;
      next_count    = count;
      next_preload  = preload;
      next_lo_buf   = lo_buf;
      next_rd_lo    = rd_lo;
      next_rdata    = 8'h00;
      if (mode == tepc_pkg::MODE_PULSE && pw_stop) begin
         next_ctrl.count_run = 1'b0; // [R6] [R7] [R9]
      end
      if (ovf) begin
         next_count = preload; // [R3]
      end else if (step) begin
         next_count = count + 16'h0001;
      end
      if (wr) begin
         case (addr)
            tepc_pkg::ADDR_COUNT_LO: next_lo_buf = wdata; // [R21]
            tepc_pkg::ADDR_COUNT_HI: begin
               next_preload = {wdata, lo_buf}; // [R21]
               if (!ctrl.count_run) begin
                  next_count = {wdata, lo_buf}; // [R20]
               end
            end
            tepc_pkg::ADDR_CONTROL: begin
               next_ctrl.mode_sel_hi   = wdata[tepc_pkg::CTRL_MODE_HI_BIT];
               next_ctrl.mode_sel_lo   = wdata[tepc_pkg::CTRL_MODE_LO_BIT];
               next_ctrl.count_run     = wdata[tepc_pkg::CTRL_RUN_BIT]; // [R15]
               next_ctrl.edge_polarity = wdata[tepc_pkg::CTRL_EDGE_BIT];
            end
            tepc_pkg::ADDR_IRQ_CTRL: begin
               next_irqc.global_irq_enable   = wdata[tepc_pkg::IRQ_GLOBAL_BIT];
               next_irqc.overflow_irq_enable = wdata[tepc_pkg::IRQ_ENABLE_BIT]; // [R11]
               next_irqc.overflow_flag       = wdata[tepc_pkg::IRQ_FLAG_BIT];
            end
            default: next_lo_buf = lo_buf;
         endcase
      end
      if (ovf) begin
         next_irqc.overflow_flag = 1'b1; // [R10]
      end
      if (rd) begin
         case (addr)
            tepc_pkg::ADDR_COUNT_LO: next_rdata = rd_lo; // [R21]
            tepc_pkg::ADDR_COUNT_HI: begin
               next_rdata = count[15:8];
               next_rd_lo = count[7:0]; // [R21]
            end
            tepc_pkg::ADDR_CONTROL: begin
               next_rdata[tepc_pkg::CTRL_MODE_HI_BIT] = ctrl.mode_sel_hi;
               next_rdata[tepc_pkg::CTRL_MODE_LO_BIT] = ctrl.mode_sel_lo;
               next_rdata[tepc_pkg::CTRL_RUN_BIT]     = ctrl.count_run;
               next_rdata[tepc_pkg::CTRL_EDGE_BIT]    = ctrl.edge_polarity;
            end
            tepc_pkg::ADDR_IRQ_CTRL: begin
               next_rdata[tepc_pkg::IRQ_GLOBAL_BIT] = irqc.global_irq_enable;
               next_rdata[tepc_pkg::IRQ_ENABLE_BIT] = irqc.overflow_irq_enable;
               next_rdata[tepc_pkg::IRQ_FLAG_BIT]   = irqc.overflow_flag;
            end
            default: next_rdata = 8'h00;
         endcase
      end
      next_irq = next_irqc.overflow_flag && next_irqc.overflow_irq_enable &&
                 next_irqc.global_irq_enable; // [R10] [R11]
      // Only the pin-clocked event counter may wake a sleeping processor
      next_wake_req = ovf && power_down && (mode == tepc_pkg::MODE_EVENT) &&
                      irqc.overflow_irq_enable; // [R14]
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl     <= tepc_pkg::tepc_ctrl_type'(tepc_pkg::CTRL_FIELDS_RESET);
         irqc     <= tepc_pkg::tepc_irq_type'(tepc_pkg::IRQ_RESET);
         count    <= tepc_pkg::COUNT_RESET;
         preload  <= tepc_pkg::COUNT_RESET;
         lo_buf   <= tepc_pkg::BYTE_RESET;
         rd_lo    <= tepc_pkg::BYTE_RESET;
         rdata    <= tepc_pkg::BYTE_RESET;
         irq      <= 1'b0;
         wake_req <= 1'b0;
      end else begin
         ctrl     <= next_ctrl;
         irqc     <= next_irqc;
         count    <= next_count;
         preload  <= next_preload;
         lo_buf   <= next_lo_buf;
         rd_lo    <= next_rd_lo;
         rdata    <= next_rdata;
         irq      <= next_irq;
         wake_req <= next_wake_req;
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   ovf_reload_a: assert property (ovf |=> count == $past(preload)) // [R3]
      else $error("overflow did not reload preload");
   ovf_flag_a: assert property (ovf |=> irqc.overflow_flag) // [R10]
      else $error("overflow flag not set");
   irq_gate_a: assert property (irq |-> $past(irqc.overflow_irq_enable) ||
                                $past(wr) && $past(addr) == tepc_pkg::ADDR_IRQ_CTRL) // [R11]
      else $error("interrupt without enable");
   off_hold_a: assert property (mode == tepc_pkg::MODE_OFF && !wr |=> $stable(count)) // [R23]
      else $error("counter moved in off mode");
   inhibit_a: assert property (rd && addr == tepc_pkg::ADDR_COUNT_HI |=> $stable(count)) // [R13]
      else $error("counter moved during read");
   run_hw_a: assert property ($fell(ctrl.count_run) && !$past(wr) |->
                              $past(mode) == tepc_pkg::MODE_PULSE) // [R9]
      else $error("run cleared by hardware outside pulse mode");
   ev_count_a: assert property (mode == tepc_pkg::MODE_EVENT && ctrl.count_run && ev_edge &&
                                !wr && !rd && count != tepc_pkg::COUNT_FULL
                                |=> count == $past(count) + 16'h0001) // [R2]
      else $error("event edge not counted");
   timer_rate_a: assert property (mode == tepc_pkg::MODE_TIMER && step |=> !step [*3]) // [R19]
      else $error("timer counted faster than a quarter clock");
   stopped_load_a: assert property (wr && addr == tepc_pkg::ADDR_COUNT_HI && !ctrl.count_run
                                    |=> count == {$past(wdata), $past(lo_buf)}) // [R20]
      else $error("stopped preload write not loaded");
   hi_read_a: assert property (rd && addr == tepc_pkg::ADDR_COUNT_HI
                               |=> rdata == $past(count[15:8]) && rd_lo == $past(count[7:0])) // [R21]
      else $error("high read did not latch low byte");
   no_wake_a: assert property (mode == tepc_pkg::MODE_TIMER |=> !wake_req) // [R14]
      else $error("internal overflow woke processor");

   // Pin and pulse-width sequencing
   pw_arm_a: assert property (mode == tepc_pkg::MODE_PULSE && pw_state == PW_WAIT // [R6] [R7]
                              |-> !step)
      else $error("pulse mode counted before the start edge");
   pw_clear_a: assert property (mode == tepc_pkg::MODE_PULSE && pw_stop && // [R6] [R7]
                                !(wr && addr == tepc_pkg::ADDR_CONTROL) |=> !ctrl.count_run)
      else $error("run not cleared at end of pulse");
   pw_hold_a: assert property (mode == tepc_pkg::MODE_PULSE && !ctrl.count_run && !wr // [R8]
                               |=> $stable(count))
      else $error("residual count moved after auto clear");
   pin_accept_a: assert property (sync2 != sync3 |=> $stable(pin_lvl)) // [R12]
      else $error("pin level taken before stages agreed");
   ev_off_a: assert property (mode == tepc_pkg::MODE_EVENT && !ctrl.count_run && !wr // [R1]
                              |=> $stable(count))
      else $error("event counter moved while stopped");
   presc_wrap_a: assert property (tick |=> presc == 2'h0) // [R19]
      else $error("prescaler did not wrap after tick");
   off_flag_a: assert property (mode == tepc_pkg::MODE_OFF |-> !ovf) // [R23]
      else $error("overflow in off mode");

   // Register access
   lo_write_a: assert property (wr && addr == tepc_pkg::ADDR_COUNT_LO // [R21]
                                |=> $stable(count) && lo_buf == $past(wdata))
      else $error("low byte write not buffered");
   hi_write_a: assert property (wr && addr == tepc_pkg::ADDR_COUNT_HI // [R21]
                                |=> preload == {$past(wdata), $past(lo_buf)})
      else $error("high byte write did not transfer low buffer");
   run_load_a: assert property (wr && addr == tepc_pkg::ADDR_COUNT_HI && ctrl.count_run // [R20]
                                |=> $stable(count))
      else $error("running preload write reached counter");
   ctrl_write_a: assert property (wr && addr == tepc_pkg::ADDR_CONTROL // [R15]
                                  |=> ctrl.count_run == $past(wdata[tepc_pkg::CTRL_RUN_BIT]))
      else $error("run bit not taken from control write");

   // Interrupt and wake-up
   flag_hold_a: assert property (irqc.overflow_flag && !wr |=> irqc.overflow_flag) // [R10]
      else $error("request flag lost without software clear");
   irq_mask_a: assert property (!irqc.overflow_irq_enable |-> !irq) // [R11]
      else $error("interrupt raised while masked");
   timer_pd_a: assert property (mode == tepc_pkg::MODE_TIMER && power_down |-> !step) // [R14]
      else $error("timer counted during power-down");
   wake_src_a: assert property (wake_req |-> $past(mode) == tepc_pkg::MODE_EVENT && // [R4] [R14]
                                $past(power_down))
      else $error("wake request not from event overflow");
endmodule : tepc_timer
`default_nettype wire

// File: dv/tepc_pin_src.sv
// External pulse and event source driving the timer input pin
`timescale 1ns/1ps
`default_nettype none
module tepc_pin_src (
   input  wire logic clk,
   output logic      pin
);
   initial pin = 1'b0;
   // Move to a new idle level and let it settle through the synchroniser
   task automatic set_idle(input logic lvl);
      @(posedge clk);
      pin <= lvl;
      repeat (8) @(posedge clk);
   endtask : set_idle
   // One pulse at the active level, then back to idle, each held w clocks
   task automatic pulse(input logic act, input int w);
      @(posedge clk);
      pin <= act;
      repeat (w) @(posedge clk);
      pin <= ~act;
      repeat (w) @(posedge clk);
   endtask : pulse
endmodule : tepc_pin_src
`default_nettype wire

// File: dv/testbench.sv
// Self-checking testbench of the timer/event counter
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic       clk;
   logic       rst_n;
   logic [1:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       pin;
   logic       power_down;
   logic       irq;
   logic       wake_req;
   logic       wake_seen;
   logic [15:0] v;
   logic [7:0] b;
   int         n_mismatch;
   int         compares;

   tepc_timer DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .timer_input_pin(pin), .power_down(power_down), .irq(irq),
      .wake_req(wake_req));
   tepc_pin_src src (.clk(clk), .pin(pin));

   initial clk = 1'b0;
   always #50 clk = ~clk;
   always @(posedge clk) if (wake_req === 1'b1) wake_seen <= 1'b1;

   task automatic conclude;
      if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : conclude

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic in_range(input logic [15:0] seen, input int lo, input int hi);
      check({15'h0, (seen >= lo && seen <= hi)}, 16'h0001);
   endtask : in_range

   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   task automatic rd_count(output logic [15:0] c);
      rd_reg(tepc_pkg::ADDR_COUNT_HI, c[15:8]);
      rd_reg(tepc_pkg::ADDR_COUNT_LO, c[7:0]);
   endtask : rd_count

   task automatic preload(input logic [15:0] p);
      wr_reg(tepc_pkg::ADDR_COUNT_LO, p[7:0]);
      wr_reg(tepc_pkg::ADDR_COUNT_HI, p[15:8]);
   endtask : preload

   // Mode bits first, run bit in a later write
   task automatic start(input logic [7:0] mode);
      wr_reg(tepc_pkg::ADDR_CONTROL, mode);
      wr_reg(tepc_pkg::ADDR_CONTROL, mode | 8'h10);
   endtask : start

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      conclude();
   end

   initial begin
      rst_n = 1'b0; addr = 2'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
      power_down = 1'b0; wake_seen = 1'b0; n_mismatch = 0; compares = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(tepc_pkg::ADDR_CONTROL, b);
      check({8'h00, b}, {8'h00, tepc_pkg::CTRL_RESET});
      rd_count(v);
      check(v, tepc_pkg::COUNT_RESET);
      check({15'h0, irq}, 16'h0000);
      preload(16'h1234);
      rd_count(v);
      check(v, 16'h1234);
      // Event mode, rising edges
      preload(16'h0010);
      start(8'h40);
      repeat (3) src.pulse(1'b1, 4);
      repeat (8) @(posedge clk);
      rd_count(v);
      check(v, 16'h0013);
      // Overflow in power-down, reload and request flag
      wr_reg(tepc_pkg::ADDR_CONTROL, 8'h40);
      preload(16'hfffe);
      wr_reg(tepc_pkg::ADDR_IRQ_CTRL, 8'h05);
      power_down <= 1'b1;
      start(8'h40);
      preload(16'hfff0);
      rd_count(v);
      check(v, 16'hfffe);
      repeat (2) src.pulse(1'b1, 4);
      repeat (8) @(posedge clk);
      rd_count(v);
      check(v, 16'hfff0);
      check({15'h0, irq}, 16'h0001);
      check({15'h0, wake_seen}, 16'h0001);
      rd_reg(tepc_pkg::ADDR_IRQ_CTRL, b);
      check({8'h00, b}, 16'h0025);
      wr_reg(tepc_pkg::ADDR_IRQ_CTRL, 8'h21);
      repeat (2) @(posedge clk);
      check({15'h0, irq}, 16'h0000);
      src.pulse(1'b1, 4);
      repeat (8) @(posedge clk);
      rd_count(v);
      check(v, 16'hfff1);
      rd_reg(tepc_pkg::ADDR_CONTROL, b);
      check({8'h00, b}, 16'h0050);
      power_down <= 1'b0;
      // Event mode, falling edges
      wr_reg(tepc_pkg::ADDR_CONTROL, 8'h40);
      src.set_idle(1'b1);
      preload(16'h0000);
      start(8'h48);
      repeat (2) src.pulse(1'b0, 4);
      repeat (8) @(posedge clk);
      rd_count(v);
      check(v, 16'h0002);
      // Timer mode on system clock divided by four
      wr_reg(tepc_pkg::ADDR_CONTROL, 8'h40);
      preload(16'h0000);
      start(8'h80);
      repeat (38) @(posedge clk);
      wr_reg(tepc_pkg::ADDR_CONTROL, 8'h80);
      rd_count(v);
      in_range(v, 9, 11);
      repeat (12) @(posedge clk);
      rd_count(v);
      in_range(v, 9, 11);
      // Pulse-width mode, low-active
      preload(16'h0000);
      start(8'hc0);
      src.pulse(1'b0, 40);
      repeat (8) @(posedge clk);
      rd_reg(tepc_pkg::ADDR_CONTROL, b);
      check({8'h00, b}, 16'h00c0);
      rd_count(v);
      in_range(v, 8, 11);
      src.pulse(1'b0, 20);
      repeat (8) @(posedge clk);
      rd_count(v);
      in_range(v, 8, 11);
      // Pulse-width mode, high-active
      src.set_idle(1'b0);
      preload(16'h0000);
      start(8'hc8);
      src.pulse(1'b1, 20);
      repeat (8) @(posedge clk);
      rd_reg(tepc_pkg::ADDR_CONTROL, b);
      check({8'h00, b}, 16'h00c8);
      rd_count(v);
      in_range(v, 3, 6);
      // Mode bits zero hold the count
      preload(16'hfffe);
      wr_reg(tepc_pkg::ADDR_IRQ_CTRL, 8'h05);
      start(8'h00);
      repeat (3) src.pulse(1'b1, 4);
      repeat (8) @(posedge clk);
      rd_count(v);
      check(v, 16'hfffe);
      check({15'h0, irq}, 16'h0000);
      conclude();
   end
endmodule : testbench
`default_nettype wire
